// *** rtl/bfspg_pkg.sv ***
// Purpose: Shared constants and types for the boot flash self-program guard.
// Assumes: One core clock, synchronous active-high reset.
// Notes:   Lock and fuse bits read 1 when unprogrammed and 0 when programmed.
package bfspg_pkg;
    // Register map of the plain register port.
    localparam int          ADDR_W   = 2;
    localparam logic [1:0]  CTRL_OFS = 2'h0;    // Self-program control register.
    localparam logic [1:0]  LOCK_OFS = 2'h1;    // Lock byte, read only.
    localparam logic [1:0]  FUSE_OFS = 2'h2;    // Fuse byte, read only.
    // Control register field positions.
    localparam int          IE_BIT   = 7;       // Ready interrupt enable.
    localparam int          BSY_BIT  = 6;       // Read-while-write busy flag.
    localparam int          RSV_BIT  = 5;       // Reserved, reads zero.
    localparam logic [7:0]  CTRL_RST = 8'h00;   // Control reset value.
    // Idle value and accepted command patterns of the low five control bits.
    localparam logic [4:0]  CMD_NONE = 5'h00;
    localparam logic [4:0]  CMD_REEN = 5'h11;   // Section re-enable.
    localparam logic [4:0]  CMD_LSET = 5'h09;   // Lock bits set.
    localparam logic [4:0]  CMD_PWR  = 5'h05;   // Page write.
    localparam logic [4:0]  CMD_PER  = 5'h03;   // Page erase.
    localparam logic [4:0]  CMD_LOAD = 5'h01;   // Page buffer load.
    // Windows in core clock cycles.
    localparam logic [2:0]  ARM_CYC  = 3'h4;    // Store instruction window.
    localparam logic [2:0]  LPM_CYC  = 3'h3;    // Lock/fuse read window.
    // Lock byte layout: {boot_hi, boot_lo, app_hi, app_lo} at bits 5..2.
    localparam int          LK_LO    = 2;
    localparam int          LK_HI    = 5;
    localparam logic [7:0]  BYTE_ONE = 8'hff;   // Unprogrammed byte.
    localparam int          FUSE_BIT = 0;       // Boot reset fuse position.
    localparam logic [15:0] APP_RVEC = 16'h0000; // Application reset address.
    localparam logic [3:0]  LK_ERASED = 4'hf;   // Lock bits after chip erase.

    // Control sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_BUSY  = 2'b10
    } bfspg_st_t;

    // Operation passed on to the flash programming neighbour.
    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_LOAD  = 3'b001,
        OP_ERASE = 3'b010,
        OP_WRITE = 3'b011
    } bfspg_op_t;

    // What the core presents each cycle.
    typedef struct packed {
        logic       store_program_memory_instr;       // Store instruction executes this cycle.
        logic       lpm;       // Load instruction executes this cycle.
        logic       z0;        // Pointer bit 0.
        logic [7:0] r0;        // Register R0.
        logic       pc_boot;   // Code runs from the boot-loader section.
        logic       tgt_boot;  // Target address lies in the boot section.
        logic       tgt_rww;   // Target lies in the read-while-write section.
        logic       gie;       // Global interrupt flag.
        logic       vec_boot;  // Interrupt vectors sit in the boot section.
    } bfspg_core_t;

    // Command handed to the flash neighbour.
    typedef struct packed {
        logic      valid;
        bfspg_op_t op;
        logic      read_while_write_section;
    } bfspg_fcmd_t;

    // State of the top module apart from the lock store and the two window timers.
    typedef struct packed {
        bfspg_st_t   st;
        logic        ie;
        logic        busy;
        logic [4:0]  cmd;
        bfspg_fcmd_t fcmd;
        logic        spm_ok;
        logic        lpm_ok;
        logic        lpm_spec;
        logic [7:0]  lpm_data;
        logic        irq;
        logic        irq_dis;
        logic        discard;
        logic        lk_prog;
        logic [3:0]  lk_data;
        logic [7:0]  rdata;
        logic        fuse;
        logic [15:0] rvec;
    } bfspg_state_t;
endpackage

// *** rtl/bfspg_win_timer.sv ***
// Purpose: Short down-counting window after a command is armed.
// Assumes: Load and stop are single-cycle pulses.
// Notes:   Active is high for LEN cycles after the load edge.
`timescale 1ns/10ps
module bfspg_win_timer #(
    parameter logic [2:0] LEN = 3'h4
) (
    input  wire logic i_clk,    // Core clock.
    input  wire logic i_rst,    // Synchronous reset.
    input  wire logic i_load,   // Start the window.
    input  wire logic i_stop,   // Close the window early.
    output logic      o_active, // Window open.
    output logic      o_expire  // Last cycle passes unused.
);
    logic [2:0] cnt_r;          // Cycles left.
    logic [2:0] cnt_nxt;        // Next count.

    // Load wins over stop, stop over counting down.
    always_comb begin
        cnt_nxt = cnt_r;
        if (i_load) begin
            cnt_nxt = LEN;
        end else if (i_stop) begin
            cnt_nxt = 3'h0;
        end else if (cnt_r != 3'h0) begin
            cnt_nxt = cnt_r - 3'h1;
        end
    end

    // Count register.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign o_active = (cnt_r != 3'h0);
    assign o_expire = (cnt_r == 3'h1) && !i_load && !i_stop;
endmodule // bfspg_win_timer

// *** rtl/bfspg_lock_store.sv ***
// Purpose: Holds the four section lock bits mirrored from the array.
// Assumes: The array value is presented on i_nv_lock during reset.
// Notes:   Programming only clears bits; only chip erase sets them.
`timescale 1ns/10ps
module bfspg_lock_store (
    input  wire logic       i_clk,       // Core clock.
    input  wire logic       i_rst,       // Synchronous reset.
    input  wire logic [3:0] i_nv_lock,   // Stored bits, caught at reset.
    input  wire logic       i_prog,      // Program from software.
    input  wire logic [3:0] i_prog_data, // Software lock data.
    input  wire logic       i_ext_prog,  // Program from programming port.
    input  wire logic [3:0] i_ext_data,  // Programming port data.
    input  wire logic       i_chip_erase,// Chip erase.
    output logic      [3:0] o_lock       // Current lock bits.
);
    logic [3:0] lock_r;                  // Lock bits.
    logic [3:0] lock_nxt;                // Next lock bits.

    // A zero in the data programs a bit; a one leaves it alone.
    always_comb begin
        lock_nxt = lock_r;
        if (i_chip_erase) begin
            lock_nxt = bfspg_pkg::LK_ERASED;
        end else begin
            if (i_prog) begin
                lock_nxt = lock_nxt & i_prog_data;
            end
            if (i_ext_prog) begin
                lock_nxt = lock_nxt & i_ext_data;
            end
        end
    end

    // Reset reloads the stored copy so reset never unprograms a bit.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lock_r <= i_nv_lock;
        end else begin
            lock_r <= lock_nxt;
        end
    end

    assign o_lock = lock_r;
endmodule // bfspg_lock_store

// *** rtl/bfspg_top.sv ***
// Purpose: Guards self-programming of program flash by the core.
// Assumes: Core strobes are one cycle and synchronous to i_clk.
// Notes:   All answers to the core come one cycle after its strobe.
//
// Behaviour
// - Locks programmable, cleared only by chip erase.
// - General write lock never blocks stores.
// - General read/write lock never blocks loads/stores.
// - Lock and fuse bits: 1 unprogrammed.
// - App mode 1: no restrictions.
// - App mode 2: stores to app suppressed.
// - App mode 3: stores suppressed, boot loads blocked.
// - App mode 4: boot loads blocked, stores allowed.
// - App modes 3/4: irqs off in app code if vectors in boot.
// - Boot mode 1: no restrictions.
// - Boot mode 2: stores to boot suppressed.
// - Boot mode 3: stores suppressed, app loads blocked.
// - Boot mode 4: app loads blocked, stores allowed.
// - Boot modes 3/4: irqs off in boot code if vectors in app.
// - Fuse picks reset vector, never software-writable.
// - Ready irq requested while enable idle.
// - Busy flag set on READ_WHILE_WRITE_SECTION program, cleared.
// - Bit 5 reads zero.
// - Re-enable needs store within four cycles.
// - Re-enable during loading discards buffer.
// - Lock set from R0 within four cycles.
// - Load within two cycles reads lock/fuse.
// - Enable arms four cycles, holds while busy.
// - Undefined command writes are ignored.
`timescale 1ns/10ps
module bfspg_top #(
    parameter logic [15:0] BOOT_RVEC = 16'h1f00  // Boot-loader start.
) (
    input  wire logic                        i_clk,        // Core clock.
    input  wire logic                        i_rst,        // Sync reset.
    input  wire logic [bfspg_pkg::ADDR_W-1:0] i_addr,      // Register address.
    input  wire logic [7:0]                  i_wdata,      // Write data.
    input  wire logic                        i_wr,         // Write strobe.
    input  wire logic                        i_rd,         // Read strobe.
    output logic      [7:0]                  o_rdata,      // Read data.
    input  wire bfspg_pkg::bfspg_core_t      i_core,       // Core request.
    input  wire logic                        i_prog_done,  // Erase/write end.
    input  wire logic [3:0]                  i_nv_lock,    // Stored locks.
    input  wire logic                        i_nv_fuse,    // Stored fuse.
    input  wire logic                        i_ext_prog,   // Port programs.
    input  wire logic [3:0]                  i_ext_data,   // Port lock data.
    input  wire logic                        i_chip_erase, // Chip erase.
    output bfspg_pkg::bfspg_fcmd_t           o_fcmd,       // Flash command.
    output logic                             o_spm_ok,     // Store granted.
    output logic                             o_lpm_ok,     // Load granted.
    output logic                             o_lpm_spec,   // Lock/fuse read.
    output logic      [7:0]                  o_lpm_data,   // Lock/fuse byte.
    output logic                             o_irq_req,    // Ready irq.
    output logic                             o_irq_dis,    // Mask irqs.
    output logic                             o_rww_block,  // Section blocked.
    output logic                             o_buf_discard,// Drop buffer.
    output logic      [15:0]                 o_reset_vec   // Reset address.
);
    import bfspg_pkg::*;

    bfspg_state_t s_r;                 // Registered state.
    bfspg_state_t s_nxt;               // Next state.
    logic [3:0]   lock;                // Lock bits from the store.
    logic         app_hi;              // Upper application lock.
    logic         app_lo;              // Lower application lock.
    logic         boot_hi;             // Upper boot lock.
    logic         boot_lo;             // Lower boot lock.
    logic         arm_load;            // Open the store window.
    logic         arm_stop;            // Close the store window.
    logic         arm_act;             // Store window open.
    logic         arm_exp;             // Store window ran out.
    logic         lw_load;             // Open the lock read window.
    logic         lw_stop;             // Close the lock read window.
    logic         lw_act;              // Lock read window open.
    logic         lw_exp;              // Lock read window ran out.
    logic [4:0]   wr_cmd;              // Low bits of a control write.
    logic         ctrl_wr;             // Control register written.
    logic         cmd_ok;              // Written pattern is a command.

    // Returns the lock byte with unused bits unprogrammed.
    function automatic logic [7:0] lock_byte(input logic [3:0] lk);
        logic [7:0] b;
        b = BYTE_ONE;
        b[LK_HI:LK_LO] = lk;
        return b;
    endfunction

    // Returns the fuse byte with unused bits unprogrammed.
    function automatic logic [7:0] fuse_byte(input logic f);
        logic [7:0] b;
        b = BYTE_ONE;
        b[FUSE_BIT] = f;
        return b;
    endfunction

    // Tells whether a write pattern is one of the defined commands.
    function automatic logic is_cmd(input logic [4:0] c);
        return (c == CMD_REEN) || (c == CMD_LSET) || (c == CMD_PWR)
            || (c == CMD_PER) || (c == CMD_LOAD);
    endfunction

    // Lock bit decode.
    assign app_lo  = lock[0];
    assign app_hi  = lock[1];
    assign boot_lo = lock[2];
    assign boot_hi = lock[3];

    // Control write decode.
    assign ctrl_wr = i_wr && (i_addr == CTRL_OFS);
    assign wr_cmd  = i_wdata[4:0];
    assign cmd_ok  = is_cmd(wr_cmd);

    // Lock bits mirrored from the nonvolatile array.
    bfspg_lock_store u_lock (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_nv_lock    (i_nv_lock),
        .i_prog       (s_r.lk_prog),
        .i_prog_data  (s_r.lk_data),
        .i_ext_prog   (i_ext_prog),
        .i_ext_data   (i_ext_data),
        .i_chip_erase (i_chip_erase),
        .o_lock       (lock)
    );

    // Window in which a store instruction uses the armed command.
    bfspg_win_timer #(
        .LEN (ARM_CYC)
    ) u_arm (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_load   (arm_load),
        .i_stop   (arm_stop),
        .o_active (arm_act),
        .o_expire (arm_exp)
    );

    // Window in which a load reads lock or fuse bits.
    bfspg_win_timer #(
        .LEN (LPM_CYC)
    ) u_lpmw (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_load   (lw_load),
        .i_stop   (lw_stop),
        .o_active (lw_act),
        .o_expire (lw_exp)
    );

    // Window control: arm on an accepted command, close the store window on use.
    always_comb begin
        arm_load = ctrl_wr && cmd_ok && (s_r.st != ST_BUSY);
        arm_stop = i_core.store_program_memory_instr && arm_act;
        lw_load  = arm_load && (wr_cmd == CMD_LSET);
        lw_stop  = arm_load && (wr_cmd != CMD_LSET);
    end

    // Sequencer and all output registers.
    always_comb begin
        s_nxt          = s_r;
        s_nxt.fcmd     = '0;
        s_nxt.spm_ok   = 1'b0;
        s_nxt.lpm_ok   = 1'b0;
        s_nxt.lpm_spec = 1'b0;
        s_nxt.lpm_data = 8'h00;
        s_nxt.discard  = 1'b0;
        s_nxt.lk_prog  = 1'b0;
        s_nxt.lk_data  = LK_ERASED;
        s_nxt.rdata    = 8'h00;

        // The general lock modes are not inputs here, so they
        // can never gate store or load instructions.

        // Interrupt enable takes every control write.
        if (ctrl_wr) begin
            s_nxt.ie = i_wdata[IE_BIT];
        end

        case (s_r.st)
            ST_IDLE, ST_ARMED: begin
                // A fresh command replaces any armed one.
                if (arm_load) begin
                    s_nxt.st  = ST_ARMED;
                    s_nxt.cmd = wr_cmd;
                    if (wr_cmd == CMD_REEN) begin
                        // Aborts any load and empties the buffer.
                        s_nxt.discard = 1'b1;
                    end
                end else if (s_r.st == ST_ARMED && arm_act && i_core.store_program_memory_instr) begin
                    s_nxt.st  = ST_IDLE;
                    s_nxt.cmd = CMD_NONE;
                    case (s_r.cmd)
                        CMD_LOAD: begin
                            // Page load reopens the section.
                            s_nxt.busy      = 1'b0;
                            s_nxt.spm_ok    = 1'b1;
                            s_nxt.fcmd      = {1'b1, OP_LOAD, i_core.tgt_rww};
                        end
                        CMD_REEN: begin
                            s_nxt.busy      = 1'b0;
                            s_nxt.spm_ok    = 1'b1;
                        end
                        CMD_LSET: begin
                            // Only R0 matters; pointer and R1 ignored.
                            s_nxt.lk_prog   = 1'b1;
                            s_nxt.lk_data   = i_core.r0[LK_HI:LK_LO];
                            s_nxt.spm_ok    = 1'b1;
                        end
                        CMD_PER, CMD_PWR: begin
                            // A programmed lower bit forbids stores;
                            // modes 1 and 4 leave it unprogrammed.
                            if ((i_core.tgt_boot && !boot_lo)
                             || (!i_core.tgt_boot && !app_lo)) begin
                                s_nxt.spm_ok = 1'b0;
                            end else begin
                                s_nxt.spm_ok    = 1'b1;
                                s_nxt.st        = ST_BUSY;
                                s_nxt.cmd       = s_r.cmd;
                                s_nxt.fcmd      = {1'b1,
                                    (s_r.cmd == CMD_PER) ? OP_ERASE : OP_WRITE,
                                    i_core.tgt_rww};
                                if (i_core.tgt_rww) begin
                                    s_nxt.busy  = 1'b1;
                                end
                            end
                        end
                        default: begin
                            s_nxt.spm_ok = 1'b0;
                        end
                    endcase
                end else if (s_r.st == ST_ARMED && (arm_exp || !arm_act)) begin
                    // Nobody used the window: drop the command.
                    s_nxt.st  = ST_IDLE;
                    s_nxt.cmd = CMD_NONE;
                end
            end
            ST_BUSY: begin
                // Enable stays high until the array is finished;
                // command writes meanwhile are ignored.
                if (i_prog_done) begin
                    s_nxt.st  = ST_IDLE;
                    s_nxt.cmd = CMD_NONE;
                end
            end
            default: begin
                s_nxt.st  = ST_IDLE;
                s_nxt.cmd = CMD_NONE;
            end
        endcase

        // Load instruction handling.
        if (i_core.lpm) begin
            if (lw_act && !lw_exp && s_r.cmd == CMD_LSET) begin
                s_nxt.lpm_spec = 1'b1;
                s_nxt.lpm_ok   = 1'b1;
                s_nxt.lpm_data = i_core.z0 ? fuse_byte(s_r.fuse)
                                           : lock_byte(lock);
            end else if (i_core.tgt_rww && s_r.busy) begin
                s_nxt.lpm_ok = 1'b0;
            end else if (i_core.pc_boot && !i_core.tgt_boot && !app_hi) begin
                s_nxt.lpm_ok = 1'b0;
            end else if (!i_core.pc_boot && i_core.tgt_boot && !boot_hi) begin
                s_nxt.lpm_ok = 1'b0;
            end else begin
                s_nxt.lpm_ok = 1'b1;
            end
        end

        // Ready interrupt stands while the enable bit is clear.
        s_nxt.irq = s_nxt.ie && i_core.gie && !s_nxt.cmd[0];

        // Vector placement against the running section.
        s_nxt.irq_dis = (!app_hi && i_core.vec_boot && !i_core.pc_boot)
                     || (!boot_hi && !i_core.vec_boot && i_core.pc_boot);

        // Register read port, data valid only the cycle after.
        if (i_rd) begin
            case (i_addr)
                CTRL_OFS: begin
                    s_nxt.rdata           = {s_r.ie, s_r.busy, 1'b0, s_r.cmd};
                    s_nxt.rdata[RSV_BIT]  = 1'b0;
                end
                LOCK_OFS: begin
                    s_nxt.rdata = lock_byte(lock);
                end
                FUSE_OFS: begin
                    s_nxt.rdata = fuse_byte(s_r.fuse);
                end
                default: begin
                    s_nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    // State register; the fuse is caught only while reset holds.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_r          <= '0;
            s_r.st       <= ST_IDLE;
            s_r.ie       <= CTRL_RST[IE_BIT];
            s_r.busy     <= CTRL_RST[BSY_BIT];
            s_r.cmd      <= CTRL_RST[4:0];
            s_r.lk_data  <= LK_ERASED;
            s_r.fuse     <= i_nv_fuse;
            s_r.rvec     <= i_nv_fuse ? APP_RVEC : BOOT_RVEC;
        end else begin
            s_r          <= s_nxt;
        end
    end

    // Outputs straight from the state register.
    assign o_rdata       = s_r.rdata;
    assign o_fcmd        = s_r.fcmd;
    assign o_spm_ok      = s_r.spm_ok;
    assign o_lpm_ok      = s_r.lpm_ok;
    assign o_lpm_spec    = s_r.lpm_spec;
    assign o_lpm_data    = s_r.lpm_data;
    assign o_irq_req     = s_r.irq;
    assign o_irq_dis     = s_r.irq_dis;
    assign o_rww_block   = s_r.busy;
    assign o_buf_discard = s_r.discard;
    assign o_reset_vec   = s_r.rvec;
endmodule // bfspg_top

// *** testbench/bfspg_assertions.sv ***
// Purpose: Port checks for the boot flash self-program guard.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the top module from the bench.
`timescale 1ns/10ps
module bfspg_assertions #(
    parameter logic [15:0] BOOT_RVEC = 16'h1f00 // Boot-loader start.
) (
    input wire logic [bfspg_pkg::ADDR_W-1:0] i_addr,      // Bus address.
    input wire logic                        i_clk,       // Core clock.
    input wire logic                        i_rst,       // Reset.
    input wire logic                        i_rd,        // Read strobe.
    input wire logic [7:0]                  o_rdata,     // Read data.
    input wire bfspg_pkg::bfspg_core_t      i_core,      // Core request.
    input wire logic                        o_spm_ok,    // Store granted.
    input wire logic                        o_lpm_spec,  // Lock/fuse read.
    input wire logic [7:0]                  o_lpm_data,  // Lock/fuse byte.
    input wire bfspg_pkg::bfspg_fcmd_t      o_fcmd,      // Flash command.
    input wire logic                        o_rww_block, // Busy flag.
    input wire logic [15:0]                 o_reset_vec  // Reset address.
);
    import bfspg_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_rsv; $past(i_rd && i_addr == CTRL_OFS) |-> !o_rdata[RSV_BIT]; endproperty
    property p_vec; o_reset_vec == APP_RVEC || o_reset_vec == BOOT_RVEC; endproperty
    property p_hold; $stable(o_reset_vec); endproperty
    property p_spm; o_spm_ok |-> $past(i_core.store_program_memory_instr); endproperty
    property p_fcmd; o_fcmd.valid |-> $past(i_core.store_program_memory_instr) && o_spm_ok; endproperty
    property p_spec; o_lpm_spec |-> $past(i_core.lpm); endproperty
    property p_pad; o_lpm_spec |-> &o_lpm_data[7:6] && o_lpm_data[1]; endproperty
    property p_busy; $rose(o_rww_block) |-> $past(i_core.store_program_memory_instr && i_core.tgt_rww); endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit read high");
    a_vec: assert property (p_vec) else $error("bad reset vector");
    a_hold: assert property (p_hold) else $error("reset vector moved");
    a_spm: assert property (p_spm) else $error("grant without store");
    a_fcmd: assert property (p_fcmd) else $error("command without store");
    a_spec: assert property (p_spec) else $error("lock read without load");
    a_pad: assert property (p_pad) else $error("unused bits not one");
    a_busy: assert property (p_busy) else $error("busy without store");
    c_spm: cover property (o_spm_ok);
    c_spec: cover property (o_lpm_spec);
    c_busy: cover property ($rose(o_rww_block));
endmodule // bfspg_assertions

// *** testbench/bfspg_core_model.sv ***
// Purpose: Behavioural core issuing store and load strobes.
// Assumes: Code runs from the boot-loader section, interrupts on.
// Notes:   Strobes last one cycle, changed just after a rising edge.
`timescale 1ns/10ps
module bfspg_core_model (
    input  wire logic              i_clk, // Core clock.
    output bfspg_pkg::bfspg_core_t o_core // Strobes and levels.
);
    import bfspg_pkg::*;
    // Idle core with no strobe raised.
    initial o_core = '{1'b0, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    // One store (s=1) or load (s=0) strobe, one cycle.
    task automatic issue(input logic s, input logic z, input logic [7:0] r, input logic w);
        @(posedge i_clk);
        o_core <= '{s, !s, z, r, 1'b1, 1'b0, w, 1'b1, 1'b1};
        @(posedge i_clk);
        {o_core.store_program_memory_instr, o_core.lpm} <= 2'b00;
    endtask
endmodule // bfspg_core_model

// *** testbench/bfspg_top_tb_top.sv ***
// Purpose: Self-checking bench for the boot flash self-program guard.
// Assumes: Plain register port; core strobes from the model.
// Notes:   Random lock data from a fixed xorshift seed.
`timescale 1ns/10ps
bind bfspg_top bfspg_assertions #(.BOOT_RVEC(BOOT_RVEC)) i_chk (.*);
module bfspg_top_tb_top;
    import bfspg_pkg::*;
    logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_done = 1'b0, i_erase = 1'b0;
    logic [1:0] i_addr = 2'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata, o_lpm_data, v, r0;
    logic o_spm_ok, o_lpm_spec, o_irq_req, o_rww_block, fuse;
    logic [15:0] o_reset_vec;
    logic [3:0] lk;
    logic [31:0] seed = 32'h00008361;
    bfspg_fcmd_t o_fcmd;
    bfspg_core_t core;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    always #5 i_clk = ~i_clk;
    bfspg_core_model i_core_m (.i_clk(i_clk), .o_core(core));
    bfspg_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_core(core), .i_prog_done(i_done),
        .i_nv_lock(4'hf), .i_nv_fuse(fuse), .i_ext_prog(1'b0), .i_ext_data(4'hf),
        .i_chip_erase(i_erase), .o_fcmd(o_fcmd), .o_spm_ok(o_spm_ok), .o_lpm_ok(),
        .o_lpm_spec(o_lpm_spec), .o_lpm_data(o_lpm_data), .o_irq_req(o_irq_req), .o_irq_dis(),
        .o_rww_block(o_rww_block), .o_buf_discard(), .o_reset_vec(o_reset_vec));
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= w;
        i_rd <= !w;
        @(posedge i_clk);
        {i_wr, i_rd} <= 2'b00;
        #1 v = o_rdata;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Cut a hang short.
    always @(posedge i_clk) if (++cyc == 3000) begin
        bad_count++;
        print_verdict();
    end
    initial begin
        r0 = xs();
        fuse = r0[0];
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        bus(0, FUSE_OFS, 0);
        chk("fuse", 16'(v[FUSE_BIT]), 16'(fuse));
        chk("rvec", o_reset_vec, fuse ? APP_RVEC : 16'h1f00);
        bus(1, CTRL_OFS, 8'hff);
        bus(0, CTRL_OFS, 0);
        chk("ctrl", 16'(v), 16'h0080);
        chk("irq", 16'(o_irq_req), 16'h0001);
        bus(1, CTRL_OFS, 8'h81);
        chk("irq", 16'(o_irq_req), 16'h0000);
        repeat (6) @(posedge i_clk);
        #1 chk("irq", 16'(o_irq_req), 16'h0001);
        $display("control test done");
        bus(1, CTRL_OFS, {3'h0, CMD_PER});
        i_core_m.issue(1'b1, 1'b0, 8'h00, 1'b1);
        #1 chk("fcmd", 16'({o_fcmd, o_rww_block}), 16'({1'b1, OP_ERASE, 2'h3}));
        bus(1, CTRL_OFS, {3'h0, CMD_REEN});
        @(posedge i_clk) i_done <= 1'b1;
        @(posedge i_clk) i_done <= 1'b0;
        #1 chk("busy", 16'(o_rww_block), 16'h0001);
        bus(1, CTRL_OFS, {3'h0, CMD_REEN});
        i_core_m.issue(1'b1, 1'b0, 8'h00, 1'b1);
        #1 chk("busy", 16'(o_rww_block), 16'h0000);
        $display("busy test done");
        lk = LK_ERASED;
        for (int i = 0; i < 4; i++) begin
            r0 = xs() & ((i == 3) ? 8'hfb : 8'hff);
            lk &= r0[LK_HI:LK_LO];
            bus(1, CTRL_OFS, {3'h0, CMD_LSET});
            i_core_m.issue(1'b1, 1'b0, r0, 1'b0);
            bus(0, LOCK_OFS, 0);
            chk("lock", 16'(v[LK_HI:LK_LO]), 16'(lk));
        end
        bus(1, CTRL_OFS, {3'h0, CMD_LSET});
        i_core_m.issue(1'b0, 1'b0, 8'h00, 1'b0);
        #1 chk("spec", 16'({o_lpm_spec, o_lpm_data}), 16'({3'h7, lk, 2'h3}));
        repeat (5) @(posedge i_clk);
        i_core_m.issue(1'b1, 1'b0, 8'h00, 1'b0);
        #1 chk("late", 16'(o_spm_ok), 16'h0000);
        bus(1, CTRL_OFS, {3'h0, CMD_PWR});
        i_core_m.issue(1'b1, 1'b0, 8'h00, 1'b0);
        #1 chk("wr", 16'({o_spm_ok, o_fcmd.valid}), 16'h0000);
        @(posedge i_clk) i_erase <= 1'b1;
        @(posedge i_clk) i_erase <= 1'b0;
        bus(0, LOCK_OFS, 0);
        chk("erase", 16'(v[LK_HI:LK_LO]), 16'(LK_ERASED));
        $display("lock test done");
        print_verdict();
    end
endmodule // bfspg_top_tb_top
